// >>> hw/hsio_consts.svh
// Constants for the high-speed I/O channel block
`ifndef HSIO_CONSTS_SVH
`define HSIO_CONSTS_SVH
`define HSIO_CH_W 12
`define HSIO_MW_W 60
`define HSIO_WPM 3'h5
`define HSIO_LAST_IDX 3'h4
`define HSIO_ADDR_W 18
`define HSIO_BUF_LEN 18'h00100
`define HSIO_IN_START 18'h00000
`define HSIO_OUT_START 18'h00100
`define HSIO_RANKS 3
`endif

// >>> hw/hsio_pkg.sv
// Types for the high-speed I/O channel block
`include "hsio_consts.svh"
package hsio_pkg;
  typedef logic [`HSIO_CH_W-1:0] hsio_word_t;
  typedef logic [`HSIO_MW_W-1:0] hsio_mword_t;
  typedef logic [`HSIO_ADDR_W-1:0] hsio_addr_t;
  typedef enum logic [1:0] {
    HSIO_OUT_IDLE = 2'b00,
    HSIO_OUT_READ = 2'b01,
    HSIO_OUT_SEND = 2'b10
  } hsio_out_state_t;
endpackage : hsio_pkg

// >>> hw/hsio_thr_if.sv
// Threshold interface between channel control and threshold logic
interface hsio_thr_if;
  import hsio_pkg::*;
  logic step;
  logic restart;
  hsio_addr_t offset;
  logic irq;
  logic lockout;
  modport ctl (output step, output restart, output offset,
               input irq, input lockout);
  modport thr (input step, input restart, input offset,
               output irq, output lockout);
endinterface : hsio_thr_if

// >>> hw/hsio_thresh.sv
// Buffer threshold detector with interrupt lockout
`include "hsio_consts.svh"
module hsio_thresh
  import hsio_pkg::*;
#(
  parameter hsio_addr_t BUF_LEN = `HSIO_BUF_LEN
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic exit_in,
  input wire logic rec_in,
  hsio_thr_if.thr t
);
  // ----------------------------------------
  // Threshold detect
  // ----------------------------------------
  localparam hsio_addr_t HALF = BUF_LEN >> 1;
  logic pending;
  logic locked;
  wire at_half = t.step && (t.offset == HALF - 18'h00001);
  wire at_end = t.step && (t.offset == BUF_LEN - 18'h00001);
  wire hit = at_half || at_end || rec_in;
  assign t.irq = pending;
  assign t.lockout = locked;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || t.restart) begin
      pending <= 1'b0;
      locked <= 1'b0;
    end else if (hit && pending) begin
      // Interrupt not yet served: hold it back and stop transfer
      locked <= 1'b1;
    end else if (hit) begin
      pending <= 1'b1;
    end else if (exit_in) begin
      pending <= 1'b0;
      locked <= 1'b0;
    end
  end
  property p_lock;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (hit && pending && !t.restart) |=> locked;
  endproperty
  a_lock: assert property (p_lock) else $error("no lockout");
  property p_irq;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (hit && !t.restart) |=> pending;
  endproperty
  a_irq: assert property (p_irq) else $error("no irq");
endmodule : hsio_thresh

// >>> hw/hsio_channel.sv
// High-speed channel: input packing and ranked output unpacking
// Function
// - Reset-input zeroes assembly counter and loads input buffer start address.
// - First received word goes to the top 12 bits of assembly register.
// - Input word and record pulses are used directly, not resynchronised.
// - Level resume held to processor while no memory write is pending and input is not locked out.
// - After five packed words, set the input write request flag.
// - While requesting, withhold resume and clear the assembly counter.
// - Words arriving while a write is pending are not processed.
// - On write accept: advance address, clear request, resume again.
// - Input raises interrupts on thresholds and record pulses.
// - Circular buffer; interrupt at midpoint and end.
// - Threshold before exit suppresses interrupt and locks transfer.
// - Record pulse zero-fills a partly assembled word before storing.
// - Output path has ranks A, B, C; processor resume not resynchronised.
// - Reset-output sets address to start and reads the first word.
// - First word clears counter, sends word and record, top 12 to A.
// - Record pulse is forwarded to the processor.
// - Word pulse loads rank A and is forwarded unless locked out.
// - Data moves A to B to C; C holds until processor acknowledges.
// - Staging acks channel control while room remains, without waiting.
// - Each ack: next word to A, word pulse, count up except on the fifth; address up on the top field only.
// - Three staged: withhold ack; processor ack shifts B to C and acks in the same cycle.
// - After fifth word enters A, request next memory word.
// - Once drained, output waits for memory to deliver the word.
// - Output raises buffer-threshold interrupts.
//
// Added by the designer: the address map of the two buffers.
`include "hsio_consts.svh"
module hsio_channel
  import hsio_pkg::*;
#(
  parameter hsio_addr_t IN_START = `HSIO_IN_START,
  parameter hsio_addr_t OUT_START = `HSIO_OUT_START,
  parameter hsio_addr_t BUF_LEN = `HSIO_BUF_LEN
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Control instructions
  input wire logic in_reset_in,
  input wire logic out_reset_in,
  input wire logic in_exit_in,
  input wire logic out_exit_in,
  // Processor to memory path
  input wire logic pp_word_in,
  input wire logic pp_rec_in,
  input wire logic [11:0] pp_data_in,
  output logic pp_resume_out,
  // Memory to processor path
  output logic pp_oword_out,
  output logic pp_orec_out,
  output logic [11:0] pp_odata_out,
  input wire logic pp_oresume_in,
  // Central memory write port
  output logic cm_wreq_out,
  output logic [17:0] cm_waddr_out,
  output logic [59:0] cm_wdata_out,
  input wire logic cm_wack_in,
  // Central memory read port
  output logic cm_rreq_out,
  output logic [17:0] cm_raddr_out,
  input wire logic cm_rvalid_in,
  input wire logic [59:0] cm_rdata_in,
  // Interrupt requests and status
  output logic in_irq_out,
  output logic out_irq_out,
  output logic in_lock_out,
  output logic out_lock_out,
  output logic [17:0] in_addr_out,
  output logic [17:0] out_addr_out
);
  // ----------------------------------------
  // Field selection
  // ----------------------------------------
  function automatic hsio_word_t field(input hsio_mword_t w,
                                       input logic [2:0] i);
    field = w[59 - 12 * i -: 12];
  endfunction : field

  // ----------------------------------------
  // Input path
  // ----------------------------------------
  hsio_mword_t asm_reg;
  logic [2:0] asm_cnt;
  hsio_addr_t in_off;
  logic wreq;
  hsio_thr_if in_t();
  // Pulses are used raw; the processor runs on this clock
  wire in_take = pp_word_in && !wreq && !in_t.lockout;
  wire in_full = in_take && (asm_cnt == `HSIO_LAST_IDX);
  wire in_rec = pp_rec_in && !wreq;
  wire in_part = in_rec && (asm_cnt != 3'h0);
  wire in_step = wreq && cm_wack_in;
  wire hsio_mword_t asm_next = asm_reg |
    ({48'h0, pp_data_in} << (48 - 12 * asm_cnt));
  assign in_t.step = in_step;
  assign in_t.restart = in_reset_in;
  assign in_t.offset = in_off;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || in_reset_in) begin
      cm_wdata_out <= '0;
      asm_reg <= '0;
      asm_cnt <= 3'h0;
      in_off <= 18'h00000;
      wreq <= 1'b0;
    end else if (in_step) begin
      wreq <= 1'b0;
      in_off <= (in_off == BUF_LEN - 18'h00001) ? 18'h00000
                : in_off + 18'h00001;
    end else if (in_full) begin
      cm_wdata_out <= asm_next;
      asm_reg <= '0;
      asm_cnt <= 3'h0;
      wreq <= 1'b1;
    end else if (in_part) begin
      // Unused fields are already zero, so the word is stored as is
      cm_wdata_out <= asm_reg;
      asm_reg <= '0;
      asm_cnt <= 3'h0;
      wreq <= 1'b1;
    end else if (in_take) begin
      asm_reg <= asm_next;
      asm_cnt <= asm_cnt + 3'h1;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pp_resume_out <= 1'b0;
    end else begin
      pp_resume_out <= !(wreq || in_full || in_part) && !in_t.lockout;
    end
  end
  hsio_thresh #(.BUF_LEN(BUF_LEN)) u_in_thr (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .exit_in(in_exit_in),
    .rec_in(in_rec),
    .t(in_t)
  );

  // ----------------------------------------
  // Output channel control
  // ----------------------------------------
  hsio_out_state_t st;
  hsio_mword_t dis_reg;
  logic [2:0] dis_cnt;
  hsio_addr_t out_off;
  logic first;
  logic rreq;
  logic cc_word;
  logic cc_rec;
  hsio_word_t rank_a;
  hsio_word_t rank_b;
  hsio_word_t rank_c;
  logic va;
  logic vb;
  logic vc;
  hsio_thr_if out_t();
  wire c_take = vc && pp_oresume_in;
  // Room remains if the word ahead can still move on
  wire room = !(va && vb && vc) || c_take;
  wire stage_ack = cc_word && room && !out_t.lockout;
  // Address moves once per memory word, when its top field is staged
  wire out_adv = (st == HSIO_OUT_SEND) && stage_ack && (dis_cnt == 3'h0);
  assign out_t.step = out_adv;
  assign out_t.restart = out_reset_in;
  assign out_t.offset = out_off;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || out_reset_in) begin
      st <= out_reset_in ? HSIO_OUT_READ : HSIO_OUT_IDLE;
      rreq <= out_reset_in;
      out_off <= 18'h00000;
      dis_reg <= '0;
      dis_cnt <= 3'h0;
      first <= 1'b1;
      cc_word <= 1'b0;
      cc_rec <= 1'b0;
    end else begin
      cc_rec <= 1'b0;
      if (stage_ack) begin
        cc_word <= 1'b0;
      end
      case (st)
        HSIO_OUT_IDLE: begin
        end
        HSIO_OUT_READ: begin
          if (cm_rvalid_in) begin
            rreq <= 1'b0;
            dis_reg <= cm_rdata_in;
            dis_cnt <= 3'h0;
            cc_word <= 1'b1;
            cc_rec <= first;
            st <= HSIO_OUT_SEND;
          end
        end
        HSIO_OUT_SEND: begin
          if (stage_ack && dis_cnt == `HSIO_LAST_IDX) begin
            rreq <= 1'b1;
            st <= HSIO_OUT_READ;
          end else if (stage_ack) begin
            dis_cnt <= dis_cnt + 3'h1;
            cc_word <= 1'b1;
          end
          if (stage_ack) begin
            first <= 1'b0;
          end
          if (out_adv) begin
            out_off <= (out_off == BUF_LEN - 18'h00001) ? 18'h00000
                       : out_off + 18'h00001;
          end
        end
        default: begin
          st <= HSIO_OUT_IDLE;
        end
      endcase
    end
  end
  hsio_thresh #(.BUF_LEN(BUF_LEN)) u_out_thr (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .exit_in(out_exit_in),
    .rec_in(1'b0),
    .t(out_t)
  );

  // ----------------------------------------
  // Staging ranks
  // ----------------------------------------
  wire b_to_c = vb && (!vc || c_take);
  wire a_to_b = va && (!vb || b_to_c);
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || out_reset_in) begin
      va <= 1'b0;
      vb <= 1'b0;
      vc <= 1'b0;
      rank_a <= 12'h000;
      rank_b <= 12'h000;
      rank_c <= 12'h000;
    end else begin
      va <= stage_ack || (va && !a_to_b);
      if (stage_ack) begin
        rank_a <= field(dis_reg, dis_cnt);
      end
      vb <= a_to_b || (vb && !b_to_c);
      if (a_to_b) begin
        rank_b <= rank_a;
      end
      vc <= b_to_c || (vc && !c_take);
      if (b_to_c) begin
        rank_c <= rank_b;
      end else if (c_take) begin
        rank_c <= 12'h000;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pp_oword_out <= 1'b0;
      pp_orec_out <= 1'b0;
      pp_odata_out <= 12'h000;
      cm_wreq_out <= 1'b0;
      cm_waddr_out <= 18'h00000;
      cm_rreq_out <= 1'b0;
      cm_raddr_out <= 18'h00000;
      in_irq_out <= 1'b0;
      out_irq_out <= 1'b0;
      in_lock_out <= 1'b0;
      out_lock_out <= 1'b0;
      in_addr_out <= 18'h00000;
      out_addr_out <= 18'h00000;
    end else begin
      pp_oword_out <= stage_ack && !out_t.lockout;
      pp_orec_out <= cc_rec;
      pp_odata_out <= rank_c;
      cm_wreq_out <= wreq && !in_step;
      cm_waddr_out <= IN_START + in_off;
      cm_rreq_out <= rreq && !cm_rvalid_in;
      cm_raddr_out <= OUT_START + out_off;
      in_irq_out <= in_t.irq;
      out_irq_out <= out_t.irq;
      in_lock_out <= in_t.lockout;
      out_lock_out <= out_t.lockout;
      in_addr_out <= IN_START + in_off;
      out_addr_out <= OUT_START + out_off;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_no_take;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (wreq && pp_word_in && !cm_wack_in) |=> $stable(asm_cnt);
  endproperty
  a_no_take: assert property (p_no_take) else $error("word taken");
  property p_full;
    @(posedge sys_clk_in) disable iff (!rst_n_in || in_reset_in)
      in_full |=> (wreq && asm_cnt == 3'h0 && !pp_resume_out);
  endproperty
  a_full: assert property (p_full) else $error("no request");
  property p_accept;
    @(posedge sys_clk_in) disable iff (!rst_n_in || in_reset_in)
      in_step |=> !wreq ##1 (pp_resume_out || in_t.lockout);
  endproperty
  a_accept: assert property (p_accept) else $error("no resume");
  property p_hold_c;
    @(posedge sys_clk_in) disable iff (!rst_n_in || out_reset_in)
      (vc && !pp_oresume_in) |=> (vc && $stable(rank_c));
  endproperty
  a_hold_c: assert property (p_hold_c) else $error("C moved");
  property p_full_stall;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (va && vb && vc && !pp_oresume_in) |-> !stage_ack;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("ack full");
  property p_next_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in || out_reset_in)
      (stage_ack && dis_cnt == `HSIO_LAST_IDX) |=> rreq ##1 cm_rreq_out;
  endproperty
  a_next_read: assert property (p_next_read) else $error("no read");
  property p_rhold;
    @(posedge sys_clk_in) disable iff (!rst_n_in || out_reset_in)
      (rreq && !cm_rvalid_in) |=> rreq;
  endproperty
  a_rhold: assert property (p_rhold) else $error("read dropped");
  property p_lock_word;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      out_t.lockout |=> !pp_oword_out;
  endproperty
  a_lock_word: assert property (p_lock_word) else $error("word leak");
  property p_part;
    @(posedge sys_clk_in) disable iff (!rst_n_in || in_reset_in)
      in_part |=> (wreq && asm_cnt == 3'h0 && cm_wdata_out[11:0] == 12'h000);
  endproperty
  a_part: assert property (p_part) else $error("no fill");
  property p_rec_fwd;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      cc_rec |=> pp_orec_out;
  endproperty
  a_rec_fwd: assert property (p_rec_fwd) else $error("no record");
  property p_adv;
    @(posedge sys_clk_in) disable iff (!rst_n_in || out_reset_in)
      out_adv |=> (out_off != $past(out_off));
  endproperty
  a_adv: assert property (p_adv) else $error("no advance");
endmodule : hsio_channel

// >>> test/hsio_mem_model.sv
// Central memory partner model for the high-speed channel
module hsio_mem_model (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] dly_in,
  input wire logic wreq_in,
  output logic wack_out,
  input wire logic rreq_in,
  input wire logic [17:0] raddr_in,
  output logic rvalid_out,
  output logic [59:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wcnt;
  logic [3:0] rcnt;
  logic wdone;
  logic rdone;
  // ----------------
  // Request answers
  // ----------------
  // Done flags stop a second answer while a request is still dropping
  always_ff @(posedge sys_clk_in) begin
    wack_out <= 1'b0;
    rvalid_out <= 1'b0;
    if (!rst_n_in) begin
      wcnt <= 4'h0;
      rcnt <= 4'h0;
      wdone <= 1'b0;
      rdone <= 1'b0;
      rdata_out <= 60'h0;
    end else begin
      // Idle read bus toggles so stale data is never mistaken for fresh
      rdata_out <= ~rdata_out;
      wdone <= wreq_in & (wdone | wack_out);
      rdone <= rreq_in & (rdone | rvalid_out);
      wcnt <= (wreq_in && !wdone && !wack_out) ? wcnt + 4'h1 : 4'h0;
      rcnt <= (rreq_in && !rdone && !rvalid_out) ? rcnt + 4'h1 : 4'h0;
      if (wreq_in && !wdone && !wack_out && wcnt == dly_in) begin
        wack_out <= 1'b1;
      end
      if (rreq_in && !rdone && !rvalid_out && rcnt == dly_in) begin
        rvalid_out <= 1'b1;
        for (int k = 0; k < 5; k++) begin
          rdata_out[59-12*k -: 12] <= {raddr_in[7:0], 4'(k)};
        end
      end
    end
  end
endmodule : hsio_mem_model

// >>> test/hsio_channel_tb.sv
// Self-checking bench for the high-speed channel
module hsio_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [17:0] OUT_BASE = 18'h00100;
  logic sys_clk_in, rst_n_in, pp_word_in, pp_resume_out, pp_oword_out;
  logic pp_orec_out, cm_wreq_out, cm_wack_in, cm_rreq_out, cm_rvalid_in;
  logic in_irq_out, out_irq_out, in_lock_out, out_lock_out;
  logic [11:0] pp_data_in, pp_odata_out, w;
  logic [17:0] cm_waddr_out, cm_raddr_out, in_addr_out, out_addr_out;
  logic [59:0] cm_wdata_out, cm_rdata_in, exp_w;
  logic [5:0] ctl;
  logic [4:0] cond;
  logic [3:0] dly;
  int mismatches, num_checks, taken, m, k;
  int seen_words = 0;
  int seen_recs = 0;
  // ------------------
  // Design and memory
  // ------------------
  hsio_channel #(.IN_START(18'h00000), .OUT_START(OUT_BASE),
                 .BUF_LEN(18'h00008)) i_hsio_channel (
    .sys_clk_in, .rst_n_in, .in_reset_in(ctl[0]), .out_reset_in(ctl[1]),
    .in_exit_in(ctl[2]), .out_exit_in(ctl[3]), .pp_word_in,
    .pp_rec_in(ctl[4]), .pp_data_in, .pp_resume_out, .pp_oword_out,
    .pp_orec_out, .pp_odata_out, .pp_oresume_in(ctl[5]), .cm_wreq_out,
    .cm_waddr_out, .cm_wdata_out, .cm_wack_in, .cm_rreq_out, .cm_raddr_out,
    .cm_rvalid_in, .cm_rdata_in, .in_irq_out, .out_irq_out, .in_lock_out,
    .out_lock_out, .in_addr_out, .out_addr_out);
  hsio_mem_model i_hsio_mem_model (.sys_clk_in, .rst_n_in, .dly_in(dly),
    .wreq_in(cm_wreq_out), .wack_out(cm_wack_in), .rreq_in(cm_rreq_out),
    .raddr_in(cm_raddr_out), .rvalid_out(cm_rvalid_in),
    .rdata_out(cm_rdata_in));
  assign cond = {!cm_wreq_out, seen_words > taken, cm_rreq_out,
                 cm_wreq_out, pp_resume_out};
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    if (pp_oword_out === 1'b1) seen_words <= seen_words + 1;
    if (pp_orec_out === 1'b1) seen_recs <= seen_recs + 1;
  end
  // -------
  // Tasks
  // -------
  task automatic check(input string name, input logic [59:0] seen, want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, want, seen);
    end
  endtask : check
  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // Bounded wait; a hang ends the run with the report
  task automatic wait_on(input int idx);
    for (int i = 0; i < 400; i++) begin
      @(negedge sys_clk_in);
      if (cond[idx] === 1'b1) return;
    end
    mismatches++;
    $display("[FAIL] wait %0d expected 1 seen 0", idx);
    final_report();
  endtask : wait_on
  task automatic pulse(input int b);
    @(posedge sys_clk_in);
    ctl[b] <= 1'b1;
    @(posedge sys_clk_in);
    ctl[b] <= 1'b0;
  endtask : pulse
  task automatic send(input logic [11:0] d, input bit polite);
    if (polite) wait_on(0);
    @(posedge sys_clk_in);
    pp_word_in <= 1'b1;
    pp_data_in <= d;
    @(posedge sys_clk_in);
    pp_word_in <= 1'b0;
  endtask : send
  // Slow processor: takes rank C some cycles after each word pulse
  task automatic take(input logic [11:0] want);
    wait_on(3);
    repeat (6) @(negedge sys_clk_in);
    check("odata", 60'(pp_odata_out), 60'(want));
    pulse(5);
    taken++;
  endtask : take
  // ----------
  // Sequence
  // ----------
  initial begin
    rst_n_in = 1'b0;
    ctl = 6'h00;
    pp_word_in = 1'b0;
    pp_data_in = 12'h000;
    dly = 4'h9;
    mismatches = 0;
    num_checks = 0;
    taken = 0;
    exp_w = 60'h0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    pulse(0);
    repeat (2) @(negedge sys_clk_in);
    check("in_addr", 60'(in_addr_out), 60'h0);
    check("resume", 60'(pp_resume_out), 60'h1);
    for (m = 0; m < 8; m++) begin
      for (k = 0; k < 5; k++) begin
        w = 12'h500 + 12'(16 * m + k);
        exp_w[59-12*k -: 12] = w;
        send(w, 1);
      end
      wait_on(1);
      check("wdata", cm_wdata_out, exp_w);
      check("waddr", 60'(cm_waddr_out), 60'(m));
      @(negedge sys_clk_in);
      check("resume", 60'(pp_resume_out), 60'h0);
      send(12'hfff, 0);
      wait_on(4);
      repeat (2) @(negedge sys_clk_in);
      if (m < 7) check("resume", 60'(pp_resume_out), 60'h1);
      check("in_addr", 60'(in_addr_out), 60'((m + 1) % 8));
      check("in_irq", 60'(in_irq_out), 60'(m >= 3));
      check("in_lock", 60'(in_lock_out), 60'(m == 7));
    end
    $display("Test input packing done");
    send(12'hfff, 0);
    pulse(2);
    repeat (2) @(negedge sys_clk_in);
    check("in_lock", 60'(in_lock_out), 60'h0);
    send(12'h0a1, 1);
    send(12'h0a2, 1);
    wait_on(0);
    pulse(4);
    wait_on(1);
    check("wdata", cm_wdata_out, {24'h0a10a2, 36'h0});
    wait_on(4);
    repeat (2) @(negedge sys_clk_in);
    check("in_irq", 60'(in_irq_out), 60'h1);
    pulse(2);
    $display("Test record done");
    dly <= 4'h3;
    pulse(1);
    wait_on(2);
    check("raddr", 60'(cm_raddr_out), 60'(OUT_BASE));
    for (m = 0; m < 4; m++) begin
      for (k = 0; k < 5; k++) begin
        take({OUT_BASE[7:0] + 8'(m), 4'(k)});
      end
    end
    @(negedge sys_clk_in);
    check("orec", 60'(seen_recs), 60'h1);
    check("out_addr", 60'(out_addr_out), 60'(OUT_BASE + 18'h00005));
    check("out_lock", 60'(out_lock_out), 60'h0);
    check("out_irq", 60'(out_irq_out), 60'h1);
    pulse(3);
    repeat (2) @(negedge sys_clk_in);
    check("out_irq", 60'(out_irq_out), 60'h0);
    $display("Test output unpacking done");
    final_report();
  end
endmodule : hsio_channel_tb
